/* inc/fhcr_cfg.svh */
`ifndef FHCR_CFG_SVH
`define FHCR_CFG_SVH
`define FHCR_ADDR_SRB     16'h03F1
`define FHCR_ADDR_DOR     16'h03F2
`define FHCR_ADDR_TDR     16'h03F3
`define FHCR_ADDR_MSR_DSR 16'h03F4
`define FHCR_ADDR_DATA    16'h03F5
`define FHCR_ADDR_DIR_CCR 16'h03F7
`define FHCR_DOR_RST      8'h00
`define FHCR_DSR_RST      8'h02
`define FHCR_DOR_SOFT_RESET_HOLD_N   2
`define FHCR_DOR_DMA_IRQ_GATE    3
`define FHCR_DOR_MOT_A    4
`define FHCR_DOR_MOT_B    5
`define FHCR_DSR_LOWPOW   6
`define FHCR_DSR_SWRST    7
`define FHCR_CLK_NS       10
`define FHCR_SRST_NS      100
`define FHCR_SRST_CYC     ((`FHCR_SRST_NS + `FHCR_CLK_NS - 1) / `FHCR_CLK_NS)
`endif

/* inc/fhcr_pkg.sv */
package fhcr_pkg;

  // Status register presentation modes.
  typedef enum logic [1:0] {
    FHCR_MODE_BASELINE,
    FHCR_MODE_LEGACY,
    FHCR_MODE_ALTERNATE
  } fhcr_smode_t;

  // Complete registered state of the block.
  typedef struct packed {
    logic [7:0] drive_output_control;
    logic [1:0] tape_sel;
    logic [1:0] boot_drv;
    logic [7:0] dsr;
    logic [1:0] rate;
    logic [3:0] srst_cnt;
    logic       ctl_rst;
    logic       lowpow;
    logic       wg_flag;
    logic       rd_flag;
    logic       wd_flag;
    logic       rd_tog;
    logic       wd_tog;
    logic       wg_prev;
    logic       wd_prev;
    logic       rd_s1;
    logic       rd_s2;
    logic       rd_s3;
    logic       rd_filt;
    logic [7:0] rdata;
    logic       rvalid;
    logic       ds_a_n;
    logic       ds_b_n;
    logic       mtr_a_n;
    logic       mtr_b_n;
    logic       dma_gate;
  } fhcr_state_t;

endpackage : fhcr_pkg

/* core/fhcr_regs.sv */
`timescale 1ns/1ns
`include "fhcr_cfg.svh"

module fhcr_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic [15:0]          io_addr,
  input  wire logic                 io_wr_stb,
  input  wire logic                 io_rd_stb,
  input  wire logic [7:0]           io_wdata,
  output logic      [7:0]           io_rdata,
  output logic                      io_rvalid,
  input  wire fhcr_pkg::fhcr_smode_t status_mode,
  input  wire logic                 swap_drives,
  input  wire logic                 tdr_enhanced,
  input  wire logic [7:0]           drive_type_config,
  input  wire logic                 write_gate_out,
  input  wire logic                 write_data_line,
  input  wire logic                 read_data_pin,
  output logic                      drive_select_a_n,
  output logic                      drive_select_b_n,
  output logic                      motor_a_out_n,
  output logic                      motor_b_out_n,
  output logic                      dma_irq_gate,
  output logic                      soft_reset_hold_n,
  output logic                      low_power_out,
  output logic      [1:0]           rate_select_bits,
  output logic      [2:0]           write_sel_a,
  output logic      [1:0]           tape_sel_out
);
  import fhcr_pkg::*;

  fhcr_state_t st_q;
  fhcr_state_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.
  ////////////////////////////////////////////////////////////////////////////

  // Picks the two drive type bits that belong to the selected drive number.
  function automatic logic [1:0] type_pair(input logic [7:0] cfg, input logic [1:0] drv);
    logic [1:0] pair;
    pair = 2'h0;
    unique case (drv)
      2'h0: pair = cfg[1:0];
      2'h1: pair = cfg[3:2];
      2'h2: pair = cfg[5:4];
      2'h3: pair = cfg[7:6];
    endcase
    return pair;
  endfunction : type_pair

  // Low-active select for one drive: its number must match and its motor bit be set.
  function automatic logic sel_n(input logic [1:0] num, input logic [1:0] want, input logic mot);
    return !((num == want) && mot);
  endfunction : sel_n

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  ////////////////////////////////////////////////////////////////////////////

  logic wr_dor;
  logic wr_tdr;
  logic wr_dsr;
  logic wr_ccr;
  logic rd_srb;
  logic rd_dor;
  logic rd_tdr;
  logic rd_msr;
  logic rd_dir;
  logic acc_data;

  // Every byte access is decoded in the cycle its strobe is seen.
  // single byte decode
  assign wr_dor   = io_wr_stb && (io_addr == `FHCR_ADDR_DOR);
  assign wr_tdr   = io_wr_stb && (io_addr == `FHCR_ADDR_TDR);
  assign wr_dsr   = io_wr_stb && (io_addr == `FHCR_ADDR_MSR_DSR);
  assign wr_ccr   = io_wr_stb && (io_addr == `FHCR_ADDR_DIR_CCR);
  assign rd_srb   = io_rd_stb && (io_addr == `FHCR_ADDR_SRB);
  assign rd_dor   = io_rd_stb && (io_addr == `FHCR_ADDR_DOR);
  assign rd_tdr   = io_rd_stb && (io_addr == `FHCR_ADDR_TDR);
  assign rd_msr   = io_rd_stb && (io_addr == `FHCR_ADDR_MSR_DSR);
  assign rd_dir   = io_rd_stb && (io_addr == `FHCR_ADDR_DIR_CCR);
  assign acc_data = (io_wr_stb || io_rd_stb) && (io_addr == `FHCR_ADDR_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////

  // Builds the whole next state from the current one, the bus strobes and the drive-side and mode inputs.
  always_comb begin
    logic       rd_fall;
    logic       wd_fall;
    logic       wg_rise;
    logic [7:0] dor_n;
    logic [7:0] second_status_view;
    logic [7:0] tape_drive_assign;
    rd_fall = 1'b0;
    wd_fall = 1'b0;
    wg_rise = 1'b0;
    dor_n   = st_q.drive_output_control;
    second_status_view     = 8'h00;
    tape_drive_assign     = 8'h00;
    st_d    = st_q;

    // Read data comes from the drive: three stages, and a change counts once stages two and three agree.
    st_d.rd_s1 = read_data_pin;
    st_d.rd_s2 = st_q.rd_s1;
    st_d.rd_s3 = st_q.rd_s2;
    if (st_q.rd_s2 == st_q.rd_s3) begin
      st_d.rd_filt = st_q.rd_s3;
    end
    rd_fall = st_q.rd_filt && (st_q.rd_s2 == st_q.rd_s3) && !st_q.rd_s3;

    // Write gate and write data are on this clock, so they need no synchroniser.
    st_d.wg_prev = write_gate_out;
    st_d.wd_prev = write_data_line;
    wg_rise      = write_gate_out && !st_q.wg_prev;
    wd_fall      = !write_data_line && st_q.wd_prev;

    // Toggle bits for the baseline view flip on every inactive edge.
    if (rd_fall) begin
      st_d.rd_tog = !st_q.rd_tog;
    end
    if (wd_fall) begin
      st_d.wd_tog = !st_q.wd_tog;
    end

    // Latched edge flags are cleared by an input register read; a new edge in that cycle wins.
    if (rd_dir) begin
      st_d.wg_flag = 1'b0;
      st_d.rd_flag = 1'b0;
      st_d.wd_flag = 1'b0;
    end
    if (wg_rise) begin
      st_d.wg_flag = 1'b1;
    end
    if (rd_fall) begin
      st_d.rd_flag = 1'b1;
    end
    if (wd_fall) begin
      st_d.wd_flag = 1'b1;
    end

    // Drive control register takes any write, whatever the controller state.
    // always writable
    if (wr_dor) begin
      dor_n = io_wdata;
    end
    st_d.drive_output_control = dor_n;

    // Tape register keeps the tape select; the boot drive field exists only in enhanced mode.
    // tape assignment
    if (wr_tdr) begin
      st_d.tape_sel = io_wdata[1:0];
      if (tdr_enhanced) begin
        st_d.boot_drv = io_wdata[3:2];
      end
    end

    // Self-clearing reset bit drops at the same edge that loads the stretch counter.
    // self clearing reset
    if (st_q.dsr[`FHCR_DSR_SWRST]) begin
      st_d.dsr[`FHCR_DSR_SWRST] = 1'b0;
    end

    // The active rate follows whichever rate source was written last.
    // last writer wins
    if (wr_ccr) begin
      st_d.rate = io_wdata[1:0];
    end
    if (wr_dsr) begin
      st_d.dsr  = io_wdata;
      st_d.rate = io_wdata[1:0];
    end

    // Reset stretch: reloads while a reset is requested, then runs down to give a minimum width.
    // minimum reset width
    if (!st_q.drive_output_control[`FHCR_DOR_SOFT_RESET_HOLD_N] || st_q.dsr[`FHCR_DSR_SWRST]) begin
      st_d.srst_cnt = 4'(`FHCR_SRST_CYC);
    end else if (st_q.srst_cnt != 4'h0) begin
      st_d.srst_cnt = st_q.srst_cnt - 4'h1;
    end
    st_d.ctl_rst = !dor_n[`FHCR_DOR_SOFT_RESET_HOLD_N] || (st_d.srst_cnt != 4'h0);

    // Manual low power ends on a reset or a data or main status access; a new entry wins.
    if (st_q.ctl_rst || rd_msr || acc_data) begin
      st_d.lowpow = 1'b0;
    end
    if (wr_dsr && io_wdata[`FHCR_DSR_LOWPOW]) begin
      st_d.lowpow = 1'b1;
    end

    // Two-drive decode of the new register value.
    // binary drive number
    if (!swap_drives) begin
      st_d.ds_a_n  = sel_n(dor_n[1:0], 2'h0, dor_n[`FHCR_DOR_MOT_A]);
      st_d.ds_b_n  = sel_n(dor_n[1:0], 2'h1, dor_n[`FHCR_DOR_MOT_B]);
      st_d.mtr_a_n = !dor_n[`FHCR_DOR_MOT_A];
      st_d.mtr_b_n = !dor_n[`FHCR_DOR_MOT_B];
    end else begin
      st_d.ds_b_n  = sel_n(dor_n[1:0], 2'h0, dor_n[`FHCR_DOR_MOT_A]);
      st_d.ds_a_n  = sel_n(dor_n[1:0], 2'h1, dor_n[`FHCR_DOR_MOT_B]);
      st_d.mtr_a_n = !dor_n[`FHCR_DOR_MOT_B];
      st_d.mtr_b_n = !dor_n[`FHCR_DOR_MOT_A];
    end

    // DMA and interrupt gate depends on the status presentation mode.
    if (status_mode == FHCR_MODE_BASELINE) begin
      st_d.dma_gate = 1'b1;
    end else begin
      st_d.dma_gate = dor_n[`FHCR_DOR_DMA_IRQ_GATE];
    end

    // Second status view as seen in the current mode.
    if (status_mode == FHCR_MODE_ALTERNATE) begin
      second_status_view[1:0] = 2'h3;
      second_status_view[2]   = st_q.wg_flag;
      second_status_view[3]   = st_q.rd_flag;
      second_status_view[4]   = st_q.wd_flag;
      second_status_view[5]   = st_q.ds_a_n;
      second_status_view[6]   = st_q.ds_b_n;
      second_status_view[7]   = 1'b1;
    end else begin
      second_status_view[7:6] = 2'h3;
      second_status_view[5]   = st_q.drive_output_control[0];
      second_status_view[4]   = st_q.wd_tog;
      second_status_view[3]   = st_q.rd_tog;
      second_status_view[2]   = write_gate_out;
      second_status_view[1]   = st_q.drive_output_control[`FHCR_DOR_MOT_B];
      second_status_view[0]   = st_q.drive_output_control[`FHCR_DOR_MOT_A];
    end

    // Tape register readback: normal mode shows only the tape select.
    // normal readback
    tape_drive_assign[1:0] = st_q.tape_sel;
    if (tdr_enhanced) begin
      tape_drive_assign[3:2] = st_q.boot_drv;
      tape_drive_assign[5:4] = type_pair(drive_type_config, st_q.drive_output_control[1:0]);
    end

    // Read answers: one cycle after the strobe, only for registers this block owns.
    st_d.rvalid = 1'b0;
    st_d.rdata  = 8'h00;
    if (rd_srb && (status_mode != FHCR_MODE_LEGACY)) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = second_status_view;
    end else if (rd_dor) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = st_q.drive_output_control;
    end else if (rd_tdr) begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = tape_drive_assign;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////////

  // Hardware reset loads documented defaults; soft reset never reaches here.
  // hardware reset values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.drive_output_control      <= `FHCR_DOR_RST;
      st_q.dsr      <= `FHCR_DSR_RST;
      st_q.rate     <= 2'(`FHCR_DSR_RST);
      st_q.ctl_rst  <= 1'b1;
      st_q.ds_a_n   <= 1'b1;
      st_q.ds_b_n   <= 1'b1;
      st_q.mtr_a_n  <= 1'b1;
      st_q.mtr_b_n  <= 1'b1;
      st_q.rd_filt  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register.
  ////////////////////////////////////////////////////////////////////////////

  assign motor_a_out_n     = st_q.mtr_a_n;
  assign motor_b_out_n     = st_q.mtr_b_n;
  assign drive_select_a_n  = st_q.ds_a_n;
  assign drive_select_b_n  = st_q.ds_b_n;
  assign dma_irq_gate      = st_q.dma_gate;
  assign soft_reset_hold_n = !st_q.ctl_rst;
  assign low_power_out     = st_q.lowpow;
  assign rate_select_bits  = st_q.rate;
  assign write_sel_a       = st_q.dsr[4:2];
  assign tape_sel_out      = st_q.tape_sel;
  assign io_rdata          = st_q.rdata;
  assign io_rvalid         = st_q.rvalid;

endmodule : fhcr_regs

/* dv/fhcr_regs_sva.sv */
`timescale 1ns/1ns

module fhcr_regs_sva (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic [15:0]           io_addr,
  input wire logic                  io_wr_stb,
  input wire logic                  io_rd_stb,
  input wire logic [7:0]            io_wdata,
  input wire logic [7:0]            io_rdata,
  input wire logic                  io_rvalid,
  input wire fhcr_pkg::fhcr_smode_t status_mode,
  input wire logic                  swap_drives,
  input wire logic                  drive_select_a_n,
  input wire logic                  drive_select_b_n,
  input wire logic                  motor_a_out_n,
  input wire logic                  motor_b_out_n,
  input wire logic                  dma_irq_gate,
  input wire logic                  soft_reset_hold_n,
  input wire logic                  low_power_out,
  input wire logic [1:0]            rate_select_bits
);
  import fhcr_pkg::*;
  // All checks run on the rising edge, off during reset.
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  // read is answered.
  a_rvalid_dor: assert property (
    io_rd_stb && io_addr == 16'h03F2 |=> io_rvalid) else $error("control read unanswered");
  a_rvalid_none: assert property (
    !io_rd_stb || io_addr == 16'h03F4 |=> !io_rvalid) else $error("answer without read");
  a_dor_readback: assert property (
    io_wr_stb && io_addr == 16'h03F2 ##2 io_rd_stb && io_addr == 16'h03F2
    |=> io_rdata == $past(io_wdata, 3)) else $error("control readback wrong");
  a_one_drive: assert property (
    drive_select_a_n || drive_select_b_n) else $error("two drives selected");
  a_motor_norm: assert property (
    io_wr_stb && io_addr == 16'h03F2 && !swap_drives
    |=> motor_a_out_n == !$past(io_wdata[4]) && motor_b_out_n == !$past(io_wdata[5]))
    else $error("normal motor decode wrong");
  a_motor_swap: assert property (
    io_wr_stb && io_addr == 16'h03F2 && swap_drives
    |=> motor_a_out_n == !$past(io_wdata[5]) && motor_b_out_n == !$past(io_wdata[4]))
    else $error("swapped motor decode wrong");
  a_srst_enter: assert property (
    io_wr_stb && io_addr == 16'h03F2 && !io_wdata[2] |=> !soft_reset_hold_n)
    else $error("soft reset not entered");
  a_srst_width: assert property (
    $fell(soft_reset_hold_n) |=> !soft_reset_hold_n [*8] ##1 !soft_reset_hold_n)
    else $error("soft reset too short");
  a_rate_follow: assert property (
    io_wr_stb && (io_addr == 16'h03F4 || io_addr == 16'h03F7)
    |=> rate_select_bits == $past(io_wdata[1:0])) else $error("rate not taken");
  a_lowpow_set: assert property (
    io_wr_stb && io_addr == 16'h03F4 && io_wdata[6] |=> low_power_out) else $error("no low power");
  a_dma_gate: assert property (
    io_wr_stb && io_addr == 16'h03F2 && io_wdata[2]
    |=> dma_irq_gate == ($past(io_wdata[3]) || $past(status_mode) == FHCR_MODE_BASELINE))
    else $error("DMA gate wrong");
endmodule : fhcr_regs_sva

bind fhcr_regs fhcr_regs_sva fhcr_regs_sva_inst (.clk, .rst_n, .io_addr, .io_wr_stb, .io_rd_stb,
  .io_wdata, .io_rdata, .io_rvalid, .status_mode, .swap_drives, .drive_select_a_n, .drive_select_b_n,
  .motor_a_out_n, .motor_b_out_n, .dma_irq_gate, .soft_reset_hold_n, .low_power_out, .rate_select_bits);

/* dv/fhcr_host.sv */
`timescale 1ns/1ns

module fhcr_host (
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr_stb,
  output logic             io_rd_stb,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  // The bus is idle at time zero.
  initial begin
    io_addr = 16'h0000;
    io_wr_stb = 1'b0;
    io_rd_stb = 1'b0;
    io_wdata = 8'h00;
  end
  ////////////////////////////////
  // byte write, one strobe cycle, stale data inverted.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr_stb = 1'b1;
    @(posedge clk);
    @(negedge clk);
    io_wr_stb = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr
  // byte read, answer taken in its only cycle.
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    io_addr = a;
    io_rd_stb = 1'b1;
    @(posedge clk);
    @(negedge clk);
    d = io_rdata;
    v = io_rvalid;
    io_rd_stb = 1'b0;
    io_addr = ~a;
  endtask : rd
endmodule : fhcr_host

/* dv/fhcr_regs_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, sn); end end

module fhcr_regs_tb;
  import fhcr_pkg::*;
  logic        clk, rst_n, io_wr_stb, io_rd_stb, io_rvalid, swap_drives, tdr_enhanced, dma_irq_gate;
  logic        write_gate_out, write_data_line, read_data_pin, low_power_out, soft_reset_hold_n;
  logic        drive_select_a_n, drive_select_b_n, motor_a_out_n, motor_b_out_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, drive_type_config;
  logic [2:0]  write_sel_a;
  logic [1:0]  rate_select_bits, tape_sel_out;
  fhcr_smode_t status_mode;
  int          fails, n_checks;

  fhcr_regs fhcr_regs_inst (.clk, .rst_n, .io_addr, .io_wr_stb, .io_rd_stb, .io_wdata, .io_rdata, .io_rvalid,
    .status_mode, .swap_drives, .tdr_enhanced, .drive_type_config, .write_gate_out, .write_data_line,
    .read_data_pin, .drive_select_a_n, .drive_select_b_n, .motor_a_out_n, .motor_b_out_n, .dma_irq_gate,
    .soft_reset_hold_n, .low_power_out, .rate_select_bits, .write_sel_a, .tape_sel_out);
  fhcr_host fhcr_host_inst (.clk, .io_addr, .io_wr_stb, .io_rd_stb, .io_wdata, .io_rdata, .io_rvalid);

  // Clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // Reads one byte and judges answer and data.
  task automatic rdc(input logic [15:0] a, input logic [7:0] e, input logic ev);
    logic [7:0] d;
    logic       v;
    fhcr_host_inst.rd(a, d, v);
    `CHK("rvalid", ev, v)
    if (ev) `CHK("rdata", e, d)
  endtask : rdc
  // Waits, bounded, for the controller to leave reset.
  task automatic wait_hold(output int n);
    n = 0;
    while (soft_reset_hold_n !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) begin
      fails++;
      $display("MISMATCH hold_release exp 1 got 0");
      give_verdict();
    end
  endtask : wait_hold
  // Values right after hardware reset.
  task automatic t_reset;
    `CHK("sel_mot", 4'hF, {drive_select_a_n, drive_select_b_n, motor_a_out_n, motor_b_out_n})
    `CHK("hold_dma_lp", 3'b000, {soft_reset_hold_n, dma_irq_gate, low_power_out})
    `CHK("rate_rst", 7'h02, {tape_sel_out, write_sel_a, rate_select_bits})
    rdc(16'h03F2, 8'h00, 1'b1);
    rdc(16'h03F4, 8'h00, 1'b0);
  endtask : t_reset
  // Drive decode table, normal and swapped: {swap, value, a_n b_n mota_n motb_n}.
  task automatic t_dor;
    logic [12:0] tab [6];
    tab = '{13'h01C5, 13'h02DA, 13'h00CF, 13'h0F7C, 13'h11CA, 13'h12D5};
    foreach (tab[i]) begin
      swap_drives = tab[i][12];
      fhcr_host_inst.wr(16'h03F2, tab[i][11:4]);
      `CHK("decode", tab[i][3:0], {drive_select_a_n, drive_select_b_n, motor_a_out_n, motor_b_out_n})
      rdc(16'h03F2, tab[i][11:4], 1'b1);
    end
    swap_drives = 1'b0;
  endtask : t_dor
  // DMA gate in legacy and baseline modes and the baseline status view.
  task automatic t_dma;
    logic [7:0] d;
    logic       v;
    status_mode = FHCR_MODE_LEGACY;
    fhcr_host_inst.wr(16'h03F2, 8'h14);
    `CHK("dma_off", 1'b0, dma_irq_gate)
    rdc(16'h03F1, 8'h00, 1'b0);
    fhcr_host_inst.wr(16'h03F2, 8'h1C);
    `CHK("dma_on", 1'b1, dma_irq_gate)
    status_mode = FHCR_MODE_BASELINE;
    fhcr_host_inst.wr(16'h03F2, 8'h14);
    `CHK("dma_base", 1'b1, dma_irq_gate)
    fhcr_host_inst.rd(16'h03F1, d, v);
    `CHK("base_view", 9'h1C1, {v, d & 8'hE7})
  endtask : t_dma
  // Soft reset by two writes keeps registers and ends manual low power.
  task automatic t_srst;
    int n;
    fhcr_host_inst.wr(16'h03F4, 8'h42);
    fhcr_host_inst.wr(16'h03F2, 8'h18);
    `CHK("hold_on", 1'b0, soft_reset_hold_n)
    fhcr_host_inst.wr(16'h03F2, 8'h1C);
    `CHK("lp_srst", 1'b0, low_power_out)
    wait_hold(n);
    `CHK("hold_len", 1'b1, n >= 8)
    rdc(16'h03F2, 8'h1C, 1'b1);
    `CHK("rate_kept", 2'b10, rate_select_bits)
  endtask : t_srst
  // Rate, precompensation, low power and self-clearing reset.
  task automatic t_rate;
    int n;
    fhcr_host_inst.wr(16'h03F4, 8'h1D);
    `CHK("rate_pre", 5'h1D, {write_sel_a, rate_select_bits})
    fhcr_host_inst.wr(16'h03F7, 8'h03);
    `CHK("rate_ccr", 2'b11, rate_select_bits)
    fhcr_host_inst.wr(16'h03F4, 8'h42);
    `CHK("lp_on", 1'b1, low_power_out)
    rdc(16'h03F5, 8'h00, 1'b0);
    `CHK("lp_data", 1'b0, low_power_out)
    fhcr_host_inst.wr(16'h03F4, 8'h42);
    rdc(16'h03F4, 8'h00, 1'b0);
    `CHK("lp_stat", 1'b0, low_power_out)
    fhcr_host_inst.wr(16'h03F4, 8'h82);
    repeat (2) @(negedge clk);
    `CHK("dsr_rst", 1'b0, soft_reset_hold_n)
    wait_hold(n);
    `CHK("dsr_len", 1'b1, n >= 9)
    rdc(16'h03F2, 8'h1C, 1'b1);
  endtask : t_rate
  // Tape register in both layouts.
  task automatic t_tape;
    fhcr_host_inst.wr(16'h03F3, 8'hFF);
    rdc(16'h03F3, 8'h03, 1'b1);
    `CHK("tape_out", 2'b11, tape_sel_out)
    tdr_enhanced = 1'b1;
    fhcr_host_inst.wr(16'h03F2, 8'h1E);
    fhcr_host_inst.wr(16'h03F3, 8'h0A);
    rdc(16'h03F3, 8'h2A, 1'b1);
    fhcr_host_inst.wr(16'h03F2, 8'h1D);
    rdc(16'h03F3, 8'h1A, 1'b1);
  endtask : t_tape
  // Latched edge flags in the alternate status view.
  task automatic t_alt;
    status_mode = FHCR_MODE_ALTERNATE;
    write_data_line = 1'b1;
    read_data_pin = 1'b1;
    repeat (6) @(negedge clk);
    rdc(16'h03F7, 8'h00, 1'b0);
    rdc(16'h03F1, 8'hE3, 1'b1);
    fhcr_host_inst.wr(16'h03F2, 8'h1C);
    write_data_line = 1'b0;
    read_data_pin = 1'b0;
    @(negedge clk);
    write_gate_out = 1'b1;
    repeat (6) @(negedge clk);
    rdc(16'h03F1, 8'hDF, 1'b1);
    rdc(16'h03F7, 8'h00, 1'b0);
    rdc(16'h03F1, 8'hC3, 1'b1);
  endtask : t_alt
  ////////////////////////////////
  // Reset for three cycles, then every scenario in turn.
  initial begin
    fails = 0;
    n_checks = 0;
    rst_n = 1'b0;
    status_mode = FHCR_MODE_BASELINE;
    swap_drives = 1'b0;
    tdr_enhanced = 1'b0;
    drive_type_config = 8'hE4;
    write_gate_out = 1'b0;
    write_data_line = 1'b0;
    read_data_pin = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_dor();
    t_dma();
    t_srst();
    t_rate();
    t_tape();
    t_alt();
    give_verdict();
  end
endmodule : fhcr_regs_tb
